//--- logic/fifo_ofs_pkg.sv
// Shared constants, types and slot decoding for the offset-programming
// and retransmit controller.
// Assumes a single clock; port edges arrive as one-cycle tick enables.
package fifo_ofs_pkg;
   // ==================================================================
   // Widths and slot layout
   localparam int DATA_W    = 18;
   localparam int OFS_W     = 18;          // One offset register
   localparam int OFS_ALL_W = 2 * OFS_W;   // Empty offset low, full high
   localparam int SEG_WIDE  = 9;           // Slot width, 18-bit port
   localparam int SEG_NARR  = 6;           // Slot width, 9-bit port
   localparam int SLOT_W    = 3;
   localparam logic [SLOT_W-1:0] SLOT_FIRST      = 3'h0;
   localparam logic [SLOT_W-1:0] SLOT_LAST_WIDE  = 3'h3;
   localparam logic [SLOT_W-1:0] SLOT_LAST_NARR  = 3'h5;
   localparam logic [SLOT_W-1:0] SLOT_EMPTY_WIDE = 3'h1;
   localparam logic [SLOT_W-1:0] SLOT_EMPTY_NARR = 3'h2;

   // ==================================================================
   // Reset values and timing counts
   localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 18'h0007F;
   localparam logic [OFS_W-1:0] FULL_OFS_RST  = 18'h0007F;
   localparam logic [1:0] WAIT_NONE  = 2'h0;
   localparam logic [1:0] WAIT_ONE   = 2'h1;
   localparam logic [1:0] WAIT_TWO   = 2'h2;  // Edges until flag valid
   localparam logic [1:0] WAIT_BLOCK = 2'h3;  // Offset partly loaded
   localparam logic [1:0] RETX_SETUP_TICKS = 2'h2;

   typedef enum logic {RD_RUN, RD_RETX_SETUP} rd_state_t;

   // ==================================================================
   // Slot decoding, used by both load and readback paths
   function automatic logic [SLOT_W-1:0] last_slot(input logic wide);
      return wide ? SLOT_LAST_WIDE : SLOT_LAST_NARR;
   endfunction

   function automatic logic [SLOT_W-1:0] empty_slot(input logic wide);
      return wide ? SLOT_EMPTY_WIDE : SLOT_EMPTY_NARR;
   endfunction

   function automatic logic [DATA_W-1:0] get_seg(
      input logic [OFS_ALL_W-1:0] ofs, input logic [SLOT_W-1:0] slot,
      input logic wide);
      int lsb;
      int wid;
      logic [DATA_W-1:0] r;
      wid = wide ? SEG_WIDE : SEG_NARR;
      lsb = int'(slot) * wid;
      r = '0;
      for (int i = 0; i < SEG_WIDE; i++) begin
         if (i < wid && lsb + i < OFS_ALL_W) r[i] = ofs[lsb + i];
      end
      return r;
   endfunction

   function automatic logic [OFS_ALL_W-1:0] put_seg(
      input logic [OFS_ALL_W-1:0] ofs, input logic [SLOT_W-1:0] slot,
      input logic wide, input logic [DATA_W-1:0] d);
      int lsb;
      int wid;
      logic [OFS_ALL_W-1:0] r;
      wid = wide ? SEG_WIDE : SEG_NARR;
      lsb = int'(slot) * wid;
      r = ofs;
      for (int i = 0; i < SEG_WIDE; i++) begin
         if (i < wid && lsb + i < OFS_ALL_W) r[lsb + i] = d[i];
      end
      return r;
   endfunction
endpackage

//--- logic/fifo_mem_if.sv
// Carrier between the controller and its storage array.
// Assumes both ends share i_clk.
`timescale 1ns/100ps
interface fifo_mem_if #(
   parameter int ADDR_W = 17,
   parameter int DATA_W = 18
);
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;

   modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

//--- logic/fifo_mem.sv
// Storage array of the FIFO, one write and one registered read port.
// Assumes the controller keeps the read address steady for two clocks.
`timescale 1ns/100ps
module fifo_mem #(
   parameter int ADDR_W = 17,
   parameter int DATA_W = 18
) (
   // Clock
   input wire logic i_clk,
   // Array access
   fifo_mem_if.mem  port
);
   logic [DATA_W-1:0] ram [0:(1 << ADDR_W)-1];

   // ==================================================================
   // Write port
   always_ff @(posedge i_clk) begin
      if (port.wr_en) ram[port.wr_addr] <= port.wr_data;
   end

   // Read data registered; sees old word on a same-address write
   always_ff @(posedge i_clk) begin
      port.rd_data <= ram[port.rd_addr];
   end
endmodule // fifo_mem

//--- logic/fifo_offset_prog_retransmit.sv
// Offset-register programming, offset readback and retransmit control
// of a deep FIFO, with the storage array instantiated below.
// Assumes port edges arrive as tick pulses at least two clocks apart.
`timescale 1ns/100ps

// Notes on behaviour
// - x9 to x9: six load writes
// - Load writes: four for x18 in, six for x9
// - x18 load order: empty lo, hi, full lo, hi
// - x9 input: one more load per register
// - Separate load and readback pointers; never simultaneous
// - Master reset homes pointers; partial keeps them
// - Memory writes interleave with offset loading
// - Write enable high pauses loading
// - Almost flags valid two edges after offset
// - Readback drives next offset slot onto output
// - Readback: four for x18 out, six for x9
// - Readback order empty then full, then wraps
// - Readback resumes where paused
// - Readback overwrites output word
// - Readback works in both timing modes
// - Retransmit taken on read edge with request low
// - Standard mode: empty low, pointer home, then high
// - Fall-through: output-ready high, first word falls
// - Almost flags update second edge after retransmit
// - Half-full updates on retransmit edge
// - Zero latency: first word out same edge
// - Latency select sampled at master reset
// - Programming method fixed at master reset
// - Fall-through select sampled at master reset
module fifo_offset_prog_retransmit
   import fifo_ofs_pkg::*;
#(
   parameter int ADDR_W = 17
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   // Device resets and straps
   input  wire logic              i_master_reset_n,
   input  wire logic              i_partial_reset_n,
   input  wire logic              i_retransmit_latency_select,
   input  wire logic              i_fallthrough_select_serial_in,
   input  wire logic              i_parallel_program_sel,
   input  wire logic              i_input_wide,
   input  wire logic              i_output_wide,
   // Write port
   input  wire logic              i_write_tick,
   input  wire logic              i_write_en_n,
   input  wire logic              i_offset_load_select_n,
   input  wire logic [DATA_W-1:0] i_data_in_bus,
   // Read port
   input  wire logic              i_read_tick,
   input  wire logic              i_read_en_n,
   input  wire logic              i_retransmit_request_n,
   // Data and flags
   output logic      [DATA_W-1:0] o_data_out_bus,
   output logic                   o_empty_flag_n,
   output logic                   o_output_ready_n,
   output logic                   o_full_flag_n,
   output logic                   o_almost_empty_flag,
   output logic                   o_almost_full_flag,
   output logic                   o_half_full_flag
);
   localparam int PTR_W = ADDR_W + 1;
   localparam logic [PTR_W-1:0] DEPTH = PTR_W'(1) << ADDR_W;
   localparam logic [PTR_W-1:0] HALF  = DEPTH >> 1;
   localparam logic [PTR_W-1:0] PTR_ZERO = '0;
   localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

   // Straps and mode
   logic fall_mode_q, zero_lat_q, parallel_q, in_wide_q, out_wide_q;
   // Offsets and their pointers
   logic [OFS_ALL_W-1:0] ofs_q;
   logic [SLOT_W-1:0]    load_ptr_q, rb_ptr_q;
   // FIFO pointers and output
   logic [PTR_W-1:0]  wptr_q, wptr_rd_q, rptr_q, rptr_d;
   logic [PTR_W-1:0]  avail, used, avail_d;
   logic [DATA_W-1:0] first_word_q, data_out_q;
   logic              out_valid_q;
   rd_state_t         rd_state_q;
   logic [1:0]        retx_cnt_q;
   // Flags
   logic       empty_n_q, full_n_q, hf_q;
   logic       aempty_s1_q, aempty_q, afull_s1_q, afull_q;
   logic [1:0] aempty_wait_q, afull_wait_q;
   // Events
   logic any_rst, wr_go, mem_wr, load_fire, load_empty_done;
   logic retx_fire, retx_normal, rb_fire, std_pop, fall_load, fall_drop;
   logic setup_done;

   fifo_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem_bus ();

   fifo_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
      .i_clk (i_clk),
      .port  (mem_bus.mem)
   );

   // ==================================================================
   // Event decode
   assign any_rst   = !i_master_reset_n || !i_partial_reset_n;
   assign avail     = wptr_rd_q - rptr_q;   // Words readable from array
   assign used      = wptr_q - rptr_q;
   assign wr_go     = i_write_tick && !i_write_en_n && !any_rst;
   assign mem_wr    = wr_go && i_offset_load_select_n && full_n_q;
   // Serial loading is not built; parallel strap gates the load path
   assign load_fire = wr_go && !i_offset_load_select_n && parallel_q;
   assign load_empty_done = load_fire && load_ptr_q == empty_slot(in_wide_q);
   assign retx_fire = i_read_tick && !i_retransmit_request_n && !any_rst
                      && rd_state_q == RD_RUN;
   assign retx_normal = retx_fire && !zero_lat_q;
   assign rb_fire   = i_read_tick && !i_read_en_n && !i_offset_load_select_n
                      && !retx_fire && !any_rst;
   assign std_pop   = !fall_mode_q && i_read_tick && !i_read_en_n
                      && i_offset_load_select_n && avail != PTR_ZERO
                      && rd_state_q == RD_RUN && !retx_fire && !any_rst;
   assign fall_load = fall_mode_q && i_read_tick && i_offset_load_select_n
                      && (!out_valid_q || !i_read_en_n)
                      && avail != PTR_ZERO && rd_state_q == RD_RUN
                      && !retx_fire && !any_rst;
   assign fall_drop = fall_mode_q && i_read_tick && !i_read_en_n
                      && i_offset_load_select_n && out_valid_q
                      && avail == PTR_ZERO && rd_state_q == RD_RUN
                      && !retx_fire && !any_rst;
   assign setup_done = rd_state_q == RD_RETX_SETUP && i_read_tick
                       && retx_cnt_q == RETX_SETUP_TICKS - 2'h1;

   // Next read pointer, shared by flags that must move on this edge
   always_comb begin
      rptr_d = rptr_q;
      if (any_rst) rptr_d = PTR_ZERO;
      else if (retx_fire) rptr_d = zero_lat_q ? PTR_ONE : PTR_ZERO;
      else if (setup_done && fall_mode_q) rptr_d = PTR_ONE;
      else if (std_pop || fall_load) rptr_d = rptr_q + PTR_ONE;
   end
   assign avail_d = wptr_rd_q - rptr_d;

   // Array hookup; read address held steady between read ticks
   assign mem_bus.wr_en   = mem_wr;
   assign mem_bus.wr_addr = wptr_q[ADDR_W-1:0];
   assign mem_bus.wr_data = i_data_in_bus;
   assign mem_bus.rd_addr = rptr_q[ADDR_W-1:0];

   // ==================================================================
   // Straps caught while master reset is held
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fall_mode_q <= 1'b0;
         zero_lat_q  <= 1'b0;
         parallel_q  <= 1'b1;
         in_wide_q   <= 1'b1;
         out_wide_q  <= 1'b1;
      end else if (!i_master_reset_n) begin
         fall_mode_q <= i_fallthrough_select_serial_in;
         zero_lat_q  <= !i_retransmit_latency_select;
         parallel_q  <= i_parallel_program_sel;
         in_wide_q   <= i_input_wide;
         out_wide_q  <= i_output_wide;
      end
   end

   // ==================================================================
   // Offset registers and load pointer; partial reset leaves them
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ofs_q      <= {FULL_OFS_RST, EMPTY_OFS_RST};
         load_ptr_q <= SLOT_FIRST;
      end else if (!i_master_reset_n) begin
         ofs_q      <= {FULL_OFS_RST, EMPTY_OFS_RST};
         load_ptr_q <= SLOT_FIRST;
      end else if (load_fire) begin
         ofs_q <= put_seg(ofs_q, load_ptr_q, in_wide_q,
                          i_data_in_bus);
         // Slot count follows input width
         load_ptr_q <= (load_ptr_q == last_slot(in_wide_q)) ? SLOT_FIRST
                       : load_ptr_q + 3'h1;
      end
   end

   // Readback pointer, advances only on readback edges
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) rb_ptr_q <= SLOT_FIRST;
      else if (!i_master_reset_n) rb_ptr_q <= SLOT_FIRST;
      else if (rb_fire)
         rb_ptr_q <= (rb_ptr_q == last_slot(out_wide_q)) ? SLOT_FIRST
                     : rb_ptr_q + 3'h1;
   end

   // ==================================================================
   // Write pointer, delayed copy for the read side, first-word copy
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wptr_q    <= PTR_ZERO;
         wptr_rd_q <= PTR_ZERO;
      end else if (any_rst) begin
         wptr_q    <= PTR_ZERO;
         wptr_rd_q <= PTR_ZERO;
      end else begin
         if (mem_wr) wptr_q <= wptr_q + PTR_ONE;
         wptr_rd_q <= wptr_q;   // Array word readable one clock later
      end
   end

   // Copy of location zero lets zero latency skip the array read
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) first_word_q <= '0;
      else if (mem_wr && wptr_q[ADDR_W-1:0] == '0)
         first_word_q <= i_data_in_bus;
   end

   // ==================================================================
   // Read side: pointer, retransmit sequencing, output register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rptr_q     <= PTR_ZERO;
         rd_state_q <= RD_RUN;
         retx_cnt_q <= 2'h0;
      end else begin
         rptr_q <= rptr_d;
         if (any_rst) rd_state_q <= RD_RUN;
         else if (retx_normal) begin
            rd_state_q <= RD_RETX_SETUP;
            retx_cnt_q <= 2'h0;
         end else if (setup_done) rd_state_q <= RD_RUN;
         else if (rd_state_q == RD_RETX_SETUP && i_read_tick)
            retx_cnt_q <= retx_cnt_q + 2'h1;
      end
   end

   // Output register; readback shares it and clobbers the word
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         data_out_q  <= '0;
         out_valid_q <= 1'b0;
      end else if (any_rst) begin
         data_out_q  <= '0;
         out_valid_q <= 1'b0;
      end else if (retx_fire && zero_lat_q) begin
         data_out_q  <= first_word_q;
         out_valid_q <= fall_mode_q;
      end else if (retx_normal) out_valid_q <= 1'b0;
      else if (setup_done && fall_mode_q) begin
         data_out_q  <= mem_bus.rd_data;
         out_valid_q <= 1'b1;
      end else if (rb_fire)
         data_out_q <= get_seg(ofs_q, rb_ptr_q, out_wide_q);
      else if (std_pop || fall_load) begin
         data_out_q  <= mem_bus.rd_data;
         out_valid_q <= fall_mode_q;
      end else if (fall_drop) out_valid_q <= 1'b0;
   end

   // ==================================================================
   // Empty and half-full from next-edge read pointer; full from current pointers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         empty_n_q <= 1'b0;
         full_n_q  <= 1'b1;
         hf_q      <= 1'b0;
      end else begin
         empty_n_q <= !any_rst && avail_d != PTR_ZERO && !retx_normal
                      && (rd_state_q == RD_RUN || setup_done);
         full_n_q  <= any_rst || used != DEPTH;
         hf_q      <= !any_rst && (wptr_q - rptr_d) > HALF;
      end
   end

   // Almost-empty: two read-edge stages, held while offset is stale
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aempty_s1_q   <= 1'b1;
         aempty_q      <= 1'b1;
         aempty_wait_q <= WAIT_NONE;
      end else if (any_rst) begin
         aempty_s1_q   <= 1'b1;
         aempty_q      <= 1'b1;
         if (!i_master_reset_n) aempty_wait_q <= WAIT_NONE;
      end else begin
         if (load_empty_done) aempty_wait_q <= WAIT_TWO;
         else if (load_fire && load_ptr_q < empty_slot(in_wide_q))
            aempty_wait_q <= WAIT_BLOCK;
         else if (i_read_tick && (aempty_wait_q == WAIT_TWO
                                  || aempty_wait_q == WAIT_ONE))
            aempty_wait_q <= aempty_wait_q - 2'h1;
         if (i_read_tick) begin
            aempty_s1_q <= avail <= PTR_W'(ofs_q[OFS_W-1:0]);
            if (aempty_wait_q < WAIT_TWO)
               aempty_q <= aempty_s1_q;
         end
      end
   end

   // Almost-full: same scheme on write edges
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         afull_s1_q   <= 1'b0;
         afull_q      <= 1'b0;
         afull_wait_q <= WAIT_NONE;
      end else if (any_rst) begin
         afull_s1_q   <= 1'b0;
         afull_q      <= 1'b0;
         if (!i_master_reset_n) afull_wait_q <= WAIT_NONE;
      end else begin
         if (load_fire && load_ptr_q == last_slot(in_wide_q))
            afull_wait_q <= WAIT_TWO;
         else if (load_fire && load_ptr_q > empty_slot(in_wide_q))
            afull_wait_q <= WAIT_BLOCK;
         else if (i_write_tick && (afull_wait_q == WAIT_TWO
                                   || afull_wait_q == WAIT_ONE))
            afull_wait_q <= afull_wait_q - 2'h1;
         if (i_write_tick) begin
            afull_s1_q <= used >= DEPTH - PTR_W'(ofs_q[OFS_ALL_W-1:OFS_W]);
            if (afull_wait_q < WAIT_TWO)
               afull_q <= afull_s1_q;
         end
      end
   end

   // ==================================================================
   // Outputs
   assign o_data_out_bus      = data_out_q;
   assign o_empty_flag_n      = fall_mode_q ? 1'b1 : empty_n_q;
   assign o_output_ready_n    = fall_mode_q ? !out_valid_q : 1'b1;
   assign o_full_flag_n       = full_n_q;
   assign o_almost_empty_flag = aempty_q;
   assign o_almost_full_flag  = afull_q;
   assign o_half_full_flag    = hf_q;

   // ==================================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_retx_std;
      retx_normal && !fall_mode_q;
   endsequence
   sequence s_retx_zero;
      retx_fire && zero_lat_q;
   endsequence

   load_order_a: assert property (load_fire && in_wide_q
      && load_ptr_q == SLOT_FIRST |=> ofs_q[SEG_WIDE-1:0]
      == $past(i_data_in_bus[SEG_WIDE-1:0]) && load_ptr_q == 3'h1)
      else $error("offset low half not loaded in order");
   load_wrap_a: assert property (load_fire && i_master_reset_n
      && load_ptr_q == last_slot(in_wide_q) |=> load_ptr_q == SLOT_FIRST)
      else $error("load pointer did not wrap");
   ptr_home_a: assert property (!i_master_reset_n |=>
      load_ptr_q == SLOT_FIRST && rb_ptr_q == SLOT_FIRST)
      else $error("master reset left offset pointers");
   ptr_keep_a: assert property (i_master_reset_n
      && !i_partial_reset_n |=> $stable(load_ptr_q) && $stable(rb_ptr_q))
      else $error("partial reset moved offset pointers");
   rb_data_a: assert property (rb_fire |=>
      o_data_out_bus == get_seg(ofs_q, $past(rb_ptr_q), out_wide_q))
      else $error("readback word wrong");
   retx_std_a: assert property (s_retx_std |=>
      !o_empty_flag_n && rptr_q == PTR_ZERO
      ##1 (!o_empty_flag_n) [*2])
      else $error("standard retransmit setup wrong");
   retx_zero_a: assert property (s_retx_zero |=>
      o_data_out_bus == $past(first_word_q) && rptr_q == PTR_ONE)
      else $error("zero latency word not loaded");
   retx_fall_a: assert property (retx_normal && fall_mode_q
      |=> o_output_ready_n)
      else $error("output ready not raised on retransmit");
   half_full_a: assert property (retx_fire |=>
      o_half_full_flag == ((wptr_q - rptr_q) > HALF))
      else $error("half full not updated on retransmit");
   aempty_hold_a: assert property (aempty_wait_q >= WAIT_TWO
      && i_nrst |=> $stable(o_almost_empty_flag) || any_rst)
      else $error("almost empty moved while offset stale");
endmodule // fifo_offset_prog_retransmit

//--- tb/fifo_host_model.sv
// Host model driving the write and read ports of the FIFO controller.
// Assumes the bench calls op(); ticks stay two clocks apart.
`timescale 1ns/100ps
module fifo_host_model
   import fifo_ofs_pkg::*;
(
   // Clock
   input  wire logic              i_clk,
   // Port controls
   output logic                   o_write_tick,
   output logic                   o_write_en_n,
   output logic                   o_read_tick,
   output logic                   o_read_en_n,
   output logic                   o_load_sel_n,
   output logic                   o_retx_n,
   output logic      [DATA_W-1:0] o_data
);
   // ===============================================================
   // Idle levels; only one port acts per call, never both at once
   initial begin
      {o_write_tick, o_read_tick} = 2'h0;
      {o_write_en_n, o_read_en_n, o_load_sel_n, o_retx_n} = 4'hF;
      o_data = '0;
   end

   // One port edge, then a quiet clock to honour tick spacing
   task automatic op(input logic wr, input logic en_n, input logic ld_n,
                     input logic rt_n, input logic [DATA_W-1:0] d);
      @(negedge i_clk);
      o_write_en_n = wr ? en_n : 1'b1;
      o_read_en_n  = wr ? 1'b1 : en_n;
      o_load_sel_n = ld_n;
      o_retx_n     = rt_n;
      o_data       = wr ? d : ~o_data;   // Stale bus inverts on each read call
      o_write_tick = wr;
      o_read_tick  = !wr;
      @(negedge i_clk);
      {o_write_tick, o_read_tick} = 2'h0;
      {o_write_en_n, o_read_en_n, o_retx_n} = 3'h7;
      @(negedge i_clk);
   endtask
endmodule // fifo_host_model

//--- tb/fifo_offset_prog_retransmit_tb.sv
// Self-checking bench: offset load/readback in both widths, retransmit.
// Assumes the host model drives ports; straps set at master reset.
`timescale 1ns/100ps
module fifo_offset_prog_retransmit_tb;
   import fifo_ofs_pkg::*;
   logic              clk, nrst, mrs_n, prs_n, lat, wide, fw, or_n, hf;
   logic              wt, we_n, rt, re_n, ld_n, rt_n, ef_n;
   logic [DATA_W-1:0] din, dout;
   logic [DATA_W-1:0] slot_v [6];
   logic [DATA_W-1:0] words  [3];
   int                n_errors, checks_done, cyc, n;

   // ===============================================================
   // Clock, timeout and instances
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end
   fifo_host_model host (.i_clk(clk), .o_write_tick(wt),
      .o_write_en_n(we_n), .o_read_tick(rt), .o_read_en_n(re_n),
      .o_load_sel_n(ld_n), .o_retx_n(rt_n), .o_data(din));
   fifo_offset_prog_retransmit #(.ADDR_W(4)) dut (.i_clk(clk),
      .i_nrst(nrst), .i_master_reset_n(mrs_n), .i_partial_reset_n(prs_n),
      .i_retransmit_latency_select(lat),
      .i_fallthrough_select_serial_in(fw), .i_parallel_program_sel(1'b1),
      .i_input_wide(wide), .i_output_wide(wide), .i_write_tick(wt),
      .i_write_en_n(we_n), .i_offset_load_select_n(ld_n),
      .i_data_in_bus(din), .i_read_tick(rt), .i_read_en_n(re_n),
      .i_retransmit_request_n(rt_n), .o_data_out_bus(dout),
      .o_empty_flag_n(ef_n), .o_output_ready_n(or_n), .o_full_flag_n(),
      .o_almost_empty_flag(), .o_almost_full_flag(),
      .o_half_full_flag(hf));

   // ===============================================================
   // Helpers: slot masking, compare, resets, verdict
   function automatic logic [DATA_W-1:0] seg(input logic [31:0] r);
      return wide ? {9'h0, r[8:0]} : {12'h0, r[5:0]};
   endfunction
   task automatic chk(input string nm, input logic [DATA_W-1:0] e,
                      input logic [DATA_W-1:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic master_reset_n(input logic l, input logic w);
      @(negedge clk);
      {lat, wide, mrs_n} = {l, w, 1'b0};
      repeat (3) @(negedge clk);
      mrs_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   task automatic final_report;
      $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ===============================================================
   // Main sequence
   initial begin
      {nrst, mrs_n, prs_n, lat, wide, cyc} = {5'h0F, 32'h0};
      {n_errors, checks_done} = {32'h0, 32'h0};
      fw = 1'b0;
      void'($urandom(32'hBB9433A9));
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      // Offset load then readback, wide then narrow slots
      for (int m = 0; m < 2; m++) begin
         master_reset_n(1'b1, m == 0);
         n = wide ? 4 : 6;
         for (int k = 0; k < n; k++) begin
            slot_v[k] = seg($urandom());
            if (k == 1) host.op(1, 0, 1, 1, $urandom());
            if (k == 2) host.op(1, 1, 0, 1, '1);
            host.op(1, 0, 0, 1, slot_v[k] | ~seg('1));
         end
         for (int k = 0; k < n + 3; k++) begin
            if (k == 1) begin
               prs_n = 1'b0;
               repeat (3) @(negedge clk);
               prs_n = 1'b1;
               repeat (2) @(negedge clk);
            end
            host.op(0, 0, 0, 1, '0);
            chk("readback", slot_v[k % n], dout);
         end
      end
      // Retransmit: normal, zero latency, then normal in fall-through
      for (int z = 0; z < 3; z++) begin
         fw = (z == 2);
         master_reset_n(z != 1, 1'b1);
         for (int k = 0; k < 3; k++) begin
            words[k] = $urandom();
            host.op(1, 0, 1, 1, words[k]);
         end
         for (int k = 0; k < 3; k++) begin
            host.op(0, 0, 1, 1, '0);
            chk("read word", words[k], dout);
         end
         host.op(0, 1, 1, 0, '0);
         chk("half full", 18'h00000, {17'h0, hf});
         if (z == 2) begin
            chk("setup ready", 18'h00001, {17'h0, or_n});
            repeat (2) host.op(0, 1, 1, 1, '0);
            chk("ready again", 18'h00000, {17'h0, or_n});
         end
         if (z == 0) begin
            chk("setup empty", 18'h00000, {17'h0, ef_n});
            repeat (2) host.op(0, 1, 1, 1, '0);
            chk("setup done", 18'h00001, {17'h0, ef_n});
            host.op(0, 0, 1, 1, '0);
         end
         chk("retx word", words[0], dout);
      end
      final_report();
   end
endmodule // fifo_offset_prog_retransmit_tb
